// file: hw/nmirt_pic.sv
/*
 * eight-level request controller: priority, in-service tracking, eoi,
 * spurious detection. assumes one acknowledge pulse per taken request.
 */
`timescale 1ns/1ps
`default_nettype none
module nmirt_pic import nmirt_pkg::*; (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// request lines and processor handshake
	input  wire logic [7:0] irq,
	input  wire logic       inta,
	input  wire logic       eoi,
	// results
	output logic            intr_r,
	output logic [7:0]      int_type_r,
	output logic [9:0]      vec_addr_r,
	output logic [7:0]      isr_r
);
	logic [7:0] irq_d_r;
	logic [7:0] irr_r;
	logic [7:0] live;
	logic [7:0] elig;
	logic [3:0] win;
	logic [3:0] top_isr;

	// lowest set bit: {found, index}
	function automatic logic [3:0] lowbit(input logic [7:0] v);
		lowbit = 4'h0;
		for (int i = NUM_LVL - 1; i >= 0; i--)
			if (v[i])
				lowbit = {1'b1, 3'(i)};
	endfunction

	always_comb begin
		live    = (irr_r | (irq & ~irq_d_r)) & irq;
		top_isr = lowbit(isr_r);
		elig    = irr_r & irq;
		for (int i = 0; i < NUM_LVL; i++)
			if (top_isr[3] && 3'(i) >= top_isr[2:0])
				elig[i] = 1'b0;
		win = lowbit(elig);
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			irq_d_r <= 8'h00;
		else
			irq_d_r <= irq;
	end

	// a request that drops before acknowledge leaves the register
	always_ff @(posedge clk) begin
		if (sys_rst)
			irr_r <= 8'h00;
		else if (inta && win[3])
			irr_r <= live & ~(8'h01 << win[2:0]);
		else
			irr_r <= live;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			int_type_r <= TYPE_SPUR;
			vec_addr_r <= 10'h000;
		end else if (inta) begin
			int_type_r <= win[3] ? TYPE_LVL0 + 8'(win[2:0]) : TYPE_SPUR;
			vec_addr_r <= VEC_BYTES * (win[3] ? 10'(TYPE_LVL0) + 10'(win[2:0]) : 10'(TYPE_SPUR));
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			isr_r <= 8'h00;
		else if (inta && win[3])
			isr_r <= isr_r | (8'h01 << win[2:0]);
		else if (eoi && top_isr[3])
			isr_r <= isr_r & ~(8'h01 << top_isr[2:0]);
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			intr_r <= 1'b0;
		else
			intr_r <= |elig;
	end

	a_spur_noisr: assert property (@(posedge clk) disable iff (sys_rst)
		inta && !win[3] |=> int_type_r == TYPE_SPUR && isr_r == $past(isr_r))
		else $error("spurious request changed in-service flags");
	a_valid_type: assert property (@(posedge clk) disable iff (sys_rst)
		inta && win[3] |=> int_type_r == TYPE_LVL0 + 8'($past(win[2:0]))
			&& vec_addr_r == {int_type_r, 2'b00})
		else $error("level not mapped to its type");
endmodule // nmirt_pic
`default_nettype wire

// file: hw/nmirt_tick.sv
/*
 * periodic timebase: one-cycle tick every PERIOD_CYC clocks.
 * assumes synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module nmirt_tick import nmirt_pkg::*; #(
	parameter int PERIOD_CYC = TICK_CYC
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	// tick
	output logic      tick_r
);
	logic [31:0] cnt_r;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_r  <= 32'h0;
			tick_r <= 1'b0;
		end else if (cnt_r == 32'(PERIOD_CYC - 1)) begin
			cnt_r  <= 32'h0;
			tick_r <= 1'b1;
		end else begin
			cnt_r  <= cnt_r + 32'h1;
			tick_r <= 1'b0;
		end
	end

	a_tick_period: assert property (@(posedge clk) disable iff (sys_rst)
		tick_r |-> cnt_r == 32'h0)
		else $error("tick not aligned to period wrap");
endmodule // nmirt_tick
`default_nettype wire

// file: hw/nmirt_top.sv
/*
 * nmi source collection, keyboard port handshake, request routing
 * and processor trap types. assumes i/o strobes are one-cycle pulses
 * synchronous to clk and source inputs are already synchronous.
 */
`timescale 1ns/1ps
`default_nettype none
module nmirt_top import nmirt_pkg::*; #(
	parameter int TICK_PERIOD_CYC = TICK_CYC
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               sys_rst,
	// processor i/o cycle
	input  wire logic [15:0]        io_addr,
	input  wire logic               io_rd,
	input  wire logic               io_wr,
	input  wire logic [7:0]         io_wdata,
	output logic [7:0]              io_rdata_r,
	// nmi sources
	input  wire logic               iochk,
	input  wire logic               kbd_restart,
	input  wire logic               fd_pwr_on,
	input  wire logic               suspend_req,
	input  wire logic               rtc_periodic,
	input  wire logic               rtc_update,
	input  wire logic               rtc_alarm,
	input  wire logic               keystroke,
	input  wire logic [NMI_NUM-1:0] nmi_clr,
	// nmi to processor
	output logic                    nmi_r,
	output logic [NMI_NUM-1:0]      nmi_pend_r,
	// hardware request sources
	input  wire logic               fd_irq,
	input  wire logic               ser_pri_irq,
	input  wire logic               ser_sec_irq,
	input  wire logic               modem_irq,
	input  wire logic               lvl2_irq,
	input  wire logic               lvl5_irq,
	input  wire logic               prn_irq,
	// maskable request handshake
	input  wire logic               inta,
	input  wire logic               eoi,
	output logic                    intr_r,
	output logic [7:0]              int_type_r,
	output logic [9:0]              vec_addr_r,
	output logic [7:0]              isr_r,
	// processor traps
	input  wire logic               div_ovf,
	input  wire logic               step_done,
	input  wire logic               step_en,
	output logic                    trap_r,
	output logic [7:0]              trap_type_r
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic         tick;
	logic         timer_irq_r;
	logic [7:0]   irq_lines;
	logic [7:0]   scan_r;
	logic [7:0]   kbctl_r;
	logic         kbd_irq_r;
	nmirt_kb_st_t kb_st_r;
	nmirt_kb_st_t kb_st_nxt;
	logic         src_d_r [NMI_NUM];
	logic [NMI_NUM-1:0] nmi_set;
	logic [NMI_NUM-1:0] nmi_pend_nxt;
	logic         rtc_any;
	logic         fd_hit;
	logic         clr_toggle;
	logic         second_kbd;
	logic         wr_scan;
	logic         rd_scan;
	logic         wr_ctl;

	// ----------------------------------------
	// port decode
	// ----------------------------------------
	function automatic logic hit(input logic [15:0] a, input logic [15:0] p);
		hit = (a == p);
	endfunction

	assign wr_scan = io_wr && hit(io_addr, PORT_SCAN);
	assign rd_scan = io_rd && hit(io_addr, PORT_SCAN);
	assign wr_ctl  = io_wr && hit(io_addr, PORT_KBCTL);
	assign clr_toggle = wr_ctl && (io_wdata[KBCTL_CLR_BIT] != kbctl_r[KBCTL_CLR_BIT]);
	// only the three register addresses count; the drive select
	// value written is never looked at
	assign fd_hit = (io_rd || io_wr) && !fd_pwr_on
		&& (hit(io_addr, PORT_FD_DOR) || hit(io_addr, PORT_FD_MSR) || hit(io_addr, PORT_FD_DATA));
	assign rtc_any = rtc_periodic || rtc_update || rtc_alarm;

	// ----------------------------------------
	// keyboard ports
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst)
			scan_r <= SCAN_RST;
		else if (wr_scan)
			scan_r <= io_wdata;
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			kbctl_r <= KBCTL_RST;
		else if (wr_ctl)
			kbctl_r <= io_wdata;
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			io_rdata_r <= 8'h00;
		else if (rd_scan)
			io_rdata_r <= scan_r;
		else if (io_rd && hit(io_addr, PORT_KBCTL))
			io_rdata_r <= kbctl_r;
		else if (io_rd)
			io_rdata_r <= 8'h00;
	end

	// level 1 request follows the loaded scan code
	always_ff @(posedge clk) begin
		if (sys_rst)
			kbd_irq_r <= 1'b0;
		else if (wr_scan)
			kbd_irq_r <= 1'b1;
		else if (clr_toggle)
			kbd_irq_r <= 1'b0;
	end

	// ----------------------------------------
	// second keyboard nmi handshake
	// ----------------------------------------
	always_comb begin
		kb_st_nxt = kb_st_r;
		unique case (kb_st_r)
			KB_IDLE:
				if (wr_scan)
					kb_st_nxt = KB_LOADED;
			KB_LOADED:
				if (rd_scan)
					kb_st_nxt = KB_READ;
			KB_READ:
				if (clr_toggle)
					kb_st_nxt = KB_HOLD;
			KB_HOLD:
				if (!isr_r[LVL_KBD] && !kbd_irq_r)
					kb_st_nxt = KB_IDLE;
		endcase
		if (wr_scan && kb_st_r != KB_HOLD)
			kb_st_nxt = KB_LOADED;
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			kb_st_r <= KB_IDLE;
		else
			kb_st_r <= kb_st_nxt;
	end

	assign second_kbd = (kb_st_r == KB_HOLD) && (kb_st_nxt == KB_IDLE);

	// ----------------------------------------
	// nmi sources
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < NMI_NUM; i++)
				src_d_r[i] <= 1'b0;
		end else begin
			src_d_r[NMI_IOCHK] <= iochk;
			src_d_r[NMI_DSKT]  <= fd_hit;
			src_d_r[NMI_SUSP]  <= suspend_req;
			src_d_r[NMI_RTC]   <= rtc_any;
			src_d_r[NMI_KBD]   <= keystroke;
		end
	end

	always_comb begin
		nmi_set            = '0;
		nmi_set[NMI_IOCHK] = iochk && !src_d_r[NMI_IOCHK];
		nmi_set[NMI_DSKT]  = fd_hit && !src_d_r[NMI_DSKT];
		nmi_set[NMI_SUSP]  = suspend_req && !src_d_r[NMI_SUSP];
		nmi_set[NMI_RTC]   = rtc_any && !src_d_r[NMI_RTC];
		nmi_set[NMI_KBD]   = (keystroke && !src_d_r[NMI_KBD]) || second_kbd;
		// set wins over clear; the check latch ignores software clears
		nmi_pend_nxt = (nmi_pend_r & ~nmi_clr) | nmi_set;
		nmi_pend_nxt[NMI_IOCHK] = nmi_set[NMI_IOCHK]
			|| (nmi_pend_r[NMI_IOCHK] && !kbd_restart);
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			nmi_pend_r <= '0;
		else
			nmi_pend_r <= nmi_pend_nxt;
	end

	// the request is edge sensitive: a new source arriving while the
	// line is already high drops it for one cycle to make a fresh edge
	always_ff @(posedge clk) begin
		if (sys_rst)
			nmi_r <= 1'b0;
		else
			nmi_r <= (|nmi_pend_nxt) && !(nmi_r && (|nmi_set));
	end

	// ----------------------------------------
	// request routing
	// ----------------------------------------
	nmirt_tick #(
		.PERIOD_CYC (TICK_PERIOD_CYC)
	) u_tick (
		.clk     (clk),
		.sys_rst (sys_rst),
		.tick_r  (tick)
	);

	// hold the timer request until the level is taken
	always_ff @(posedge clk) begin
		if (sys_rst)
			timer_irq_r <= 1'b0;
		else if (tick)
			timer_irq_r <= 1'b1;
		else if (isr_r[LVL_TIMER])
			timer_irq_r <= 1'b0;
	end

	always_comb begin
		irq_lines            = 8'h00;
		irq_lines[LVL_TIMER] = timer_irq_r;
		irq_lines[LVL_KBD]   = kbd_irq_r;
		irq_lines[2]         = lvl2_irq;
		irq_lines[LVL_SEC]   = ser_sec_irq || modem_irq;
		irq_lines[LVL_PRI]   = ser_pri_irq;
		irq_lines[5]         = lvl5_irq;
		irq_lines[LVL_DSKT]  = fd_irq;
		irq_lines[LVL_PRN]   = prn_irq;
	end

	nmirt_pic u_pic (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.irq        (irq_lines),
		.inta       (inta),
		.eoi        (eoi),
		.intr_r     (intr_r),
		.int_type_r (int_type_r),
		.vec_addr_r (vec_addr_r),
		.isr_r      (isr_r)
	);

	// ----------------------------------------
	// processor traps
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			trap_r      <= 1'b0;
			trap_type_r <= TYPE_DIVIDE;
		end else begin
			trap_r <= div_ovf || (step_en && step_done);
			if (div_ovf)
				trap_type_r <= TYPE_DIVIDE;
			else if (step_en && step_done)
				trap_type_r <= TYPE_STEP;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_iochk_sticky: assert property (@(posedge clk) disable iff (sys_rst)
		nmi_pend_r[NMI_IOCHK] && !kbd_restart |=> nmi_pend_r[NMI_IOCHK])
		else $error("i/o check latch lost without restart");
	a_fd_nmi: assert property (@(posedge clk) disable iff (sys_rst)
		io_wr && hit(io_addr, PORT_FD_DOR) && !fd_pwr_on |=> nmi_pend_r[NMI_DSKT])
		else $error("powered-off diskette access gave no nmi");
	a_fd_powered: assert property (@(posedge clk) disable iff (sys_rst)
		fd_pwr_on && !nmi_pend_r[NMI_DSKT] |=> !nmi_pend_r[NMI_DSKT])
		else $error("diskette nmi while powered");
	a_susp_nmi: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(suspend_req) |=> nmi_pend_r[NMI_SUSP] ##1 nmi_r)
		else $error("suspend not forwarded");
	a_rtc_nmi: assert property (@(posedge clk) disable iff (sys_rst)
		rtc_alarm && !src_d_r[NMI_RTC] |=> nmi_pend_r[NMI_RTC])
		else $error("rtc condition not forwarded");
	a_key_nmi: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(keystroke) |=> nmi_pend_r[NMI_KBD])
		else $error("keystroke nmi missing");
	a_kbd_hold: assert property (@(posedge clk) disable iff (sys_rst)
		kb_st_r == KB_HOLD && isr_r[LVL_KBD] |=> kb_st_r == KB_HOLD)
		else $error("second keyboard nmi released early");
	a_scan_irq: assert property (@(posedge clk) disable iff (sys_rst)
		wr_scan |=> kbd_irq_r ##1 irq_lines[LVL_KBD])
		else $error("scan code write gave no level 1 request");
	a_trap_type: assert property (@(posedge clk) disable iff (sys_rst)
		div_ovf |=> trap_r && trap_type_r == TYPE_DIVIDE)
		else $error("divide overflow not typed 0");
	a_step_type: assert property (@(posedge clk) disable iff (sys_rst)
		step_en && step_done && !div_ovf |=> trap_r && trap_type_r == TYPE_STEP)
		else $error("single step not typed 1");
endmodule // nmirt_top
`default_nettype wire

// file: shared/nmirt_pkg.sv
/*
 * constants for the nmi source and request routing block.
 * assumes a 40 mhz system clock and byte-wide i/o port accesses.
 */
`default_nettype none
package nmirt_pkg;
	// ----------------------------------------
	// i/o port addresses
	// ----------------------------------------
	localparam logic [15:0] PORT_SCAN    = 16'h0060;
	localparam logic [15:0] PORT_KBCTL   = 16'h0061;
	localparam logic [15:0] PORT_FD_DOR  = 16'h03f2;
	localparam logic [15:0] PORT_FD_MSR  = 16'h03f4;
	localparam logic [15:0] PORT_FD_DATA = 16'h03f5;
	// ----------------------------------------
	// fields and reset values
	// ----------------------------------------
	localparam int          KBCTL_CLR_BIT = 7;
	localparam logic [7:0]  SCAN_RST      = 8'h00;
	localparam logic [7:0]  KBCTL_RST     = 8'h00;
	// ----------------------------------------
	// interrupt types
	// ----------------------------------------
	localparam logic [7:0]  TYPE_DIVIDE = 8'h00;
	localparam logic [7:0]  TYPE_STEP   = 8'h01;
	localparam logic [7:0]  TYPE_LVL0   = 8'h08;
	localparam logic [7:0]  TYPE_SPUR   = 8'h0f;
	localparam logic [9:0]  VEC_BYTES   = 10'h004;
	localparam int          NUM_LVL     = 8;
	// ----------------------------------------
	// hardware request levels
	// ----------------------------------------
	localparam int LVL_TIMER = 0;
	localparam int LVL_KBD   = 1;
	localparam int LVL_SEC   = 3;
	localparam int LVL_PRI   = 4;
	localparam int LVL_DSKT  = 6;
	localparam int LVL_PRN   = 7;
	// ----------------------------------------
	// nmi source bits
	// ----------------------------------------
	localparam int NMI_IOCHK = 0;
	localparam int NMI_DSKT  = 1;
	localparam int NMI_SUSP  = 2;
	localparam int NMI_RTC   = 3;
	localparam int NMI_KBD   = 4;
	localparam int NMI_NUM   = 5;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam longint CLK_PERIOD_PS = 25000;
	localparam longint TICK_PERIOD_MS = 55;
	localparam int     TICK_CYC = int'((TICK_PERIOD_MS * 64'd1000000000) / CLK_PERIOD_PS);
	// ----------------------------------------
	// keyboard handshake states
	// ----------------------------------------
	typedef enum logic [1:0] {
		KB_IDLE   = 2'b00,
		KB_LOADED = 2'b01,
		KB_READ   = 2'b10,
		KB_HOLD   = 2'b11
	} nmirt_kb_st_t;
endpackage
`default_nettype wire

// file: tb/nmi_source_and_irq_routing_test.sv
/*
 * self-checking bench for the nmi source and request routing block.
 * assumes nmirt_host drives the i/o cycle and the acknowledge pins.
 */
`timescale 1ns/1ps
`default_nettype none
module nmi_source_and_irq_routing_test import nmirt_pkg::*;;
	localparam int TP = 200;
	localparam int TIMEOUT = 20000;
	localparam int PB [5] = '{NMI_SUSP, NMI_RTC, NMI_RTC, NMI_RTC, NMI_KBD};
	localparam logic [7:0] LT [7] = '{8'h0e, 8'h0c, 8'h0b, 8'h0b, 8'h0a, 8'h0d, 8'h0f};
	localparam logic [15:0] FA [4] = '{PORT_FD_DOR, PORT_FD_MSR, PORT_FD_DATA, 16'h03f3};
	localparam logic [2:0] TV [4] = '{3'b100, 3'b011, 3'b010, 3'b111};
	localparam logic [7:0] TT [4] = '{TYPE_DIVIDE, TYPE_STEP, 8'h00, TYPE_DIVIDE};
	localparam int TH [4] = '{1, 1, 0, 1};
	logic clk = 1'b0, sys_rst, iochk, kbd_restart, fd_pwr_on, nmi_r, inta, eoi, intr_r;
	logic io_rd, io_wr, div_ovf, step_done, step_en, trap_r;
	logic [15:0] io_addr;
	logic [7:0] io_wdata, io_rdata_r, int_type_r, isr_r, trap_type_r, d, ty;
	logic [9:0] vec_addr_r;
	logic [4:0] src, nmi_clr, nmi_pend_r;
	logic [6:0] req;
	int cyc = 0, t0, hits, err_count = 0, tests_run = 0;

	always #12.5 clk = ~clk;

	nmirt_top #(.TICK_PERIOD_CYC(TP)) dut (
		.clk(clk), .sys_rst(sys_rst), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
		.io_wdata(io_wdata), .io_rdata_r(io_rdata_r), .iochk(iochk), .kbd_restart(kbd_restart),
		.fd_pwr_on(fd_pwr_on), .suspend_req(src[0]), .rtc_periodic(src[1]), .rtc_update(src[2]),
		.rtc_alarm(src[3]), .keystroke(src[4]), .nmi_clr(nmi_clr), .nmi_r(nmi_r),
		.nmi_pend_r(nmi_pend_r), .fd_irq(req[0]), .ser_pri_irq(req[1]), .ser_sec_irq(req[2]),
		.modem_irq(req[3]), .lvl2_irq(req[4]), .lvl5_irq(req[5]), .prn_irq(req[6]),
		.inta(inta), .eoi(eoi), .intr_r(intr_r), .int_type_r(int_type_r), .vec_addr_r(vec_addr_r),
		.isr_r(isr_r), .div_ovf(div_ovf), .step_done(step_done), .step_en(step_en),
		.trap_r(trap_r), .trap_type_r(trap_type_r)
	);
	nmirt_host h (
		.clk(clk), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
		.io_rdata_r(io_rdata_r), .inta(inta), .eoi(eoi)
	);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wait_intr;
		int n = 0;
		while (intr_r !== 1'b1 && n < 400) begin
			step(1);
			n++;
		end
		chk(16'(intr_r), 16'h0001);
	endtask
	task automatic take(input logic [7:0] t);
		h.pulse(1'b0);
		// a timer tick may win the acknowledge; serve it and retry
		while (int_type_r === TYPE_LVL0 && t !== TYPE_LVL0) begin
			h.pulse(1'b1);
			h.pulse(1'b0);
		end
		chk(16'(int_type_r), 16'(t));
		chk(16'(vec_addr_r), 16'({t, 2'b00}));
	endtask
	task automatic clr_nmi(input int b);
		@(posedge clk) nmi_clr <= 5'h01 << b;
		@(posedge clk) nmi_clr <= 5'h00;
		step(3);
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == TIMEOUT) begin
			err_count++;
			test_done();
		end
	end
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		sys_rst <= 1'b1;
		iochk <= 1'b0;
		kbd_restart <= 1'b0;
		fd_pwr_on <= 1'b1;
		src <= 5'h00;
		nmi_clr <= 5'h00;
		req <= 7'h00;
		div_ovf <= 1'b0;
		step_done <= 1'b0;
		step_en <= 1'b0;
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		step(1);
		chk(16'(int_type_r), 16'(TYPE_SPUR));
		chk(16'({nmi_r, nmi_pend_r, intr_r, isr_r}), 16'h0000);
		h.cyc_io(PORT_SCAN, 1'b0, 8'h00, d);
		chk(16'(d), 16'(SCAN_RST));
		h.cyc_io(16'h0062, 1'b0, 8'h00, d);
		chk(16'(d), 16'h0000);
		wait_intr();
		t0 = cyc;
		take(TYPE_LVL0);
		chk(16'(isr_r), 16'h0001);
		h.pulse(1'b1);
		wait_intr();
		chk(16'(cyc - t0), 16'(TP));
		for (int i = 0; i < 5; i++) begin
			@(posedge clk) src <= 5'h01 << i;
			step(4);
			chk(16'({nmi_r, nmi_pend_r}), 16'({1'b1, 5'h01 << PB[i]}));
			@(posedge clk) src <= 5'h00;
			clr_nmi(PB[i]);
			chk(16'({nmi_r, nmi_pend_r}), 16'h0000);
		end
		@(posedge clk) iochk <= 1'b1;
		@(posedge clk) iochk <= 1'b0;
		step(3);
		chk(16'({nmi_r, nmi_pend_r}), 16'h0021);
		clr_nmi(NMI_IOCHK);
		chk(16'(nmi_pend_r), 16'h0001);
		@(posedge clk) kbd_restart <= 1'b1;
		@(posedge clk) kbd_restart <= 1'b0;
		step(3);
		chk(16'({nmi_r, nmi_pend_r}), 16'h0000);
		@(posedge clk) fd_pwr_on <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			// even positions write, so the register write path is hit too
			h.cyc_io(FA[i], !i[0], 8'h0c, d);
			step(2);
			chk(16'(nmi_pend_r[NMI_DSKT]), 16'(i < 3));
			clr_nmi(NMI_DSKT);
		end
		@(posedge clk) fd_pwr_on <= 1'b1;
		h.cyc_io(PORT_FD_DOR, 1'b1, 8'h1c, d);
		h.cyc_io(PORT_FD_DOR, 1'b1, 8'h2d, d);
		step(3);
		chk(16'(nmi_pend_r), 16'h0000);
		h.cyc_io(PORT_SCAN, 1'b1, 8'ha5, d);
		step(3);
		take(TYPE_LVL0 + 8'(LVL_KBD));
		chk(16'(isr_r), 16'h0002);
		h.cyc_io(PORT_SCAN, 1'b0, 8'h00, d);
		chk(16'(d), 16'h00a5);
		h.cyc_io(PORT_KBCTL, 1'b1, 8'h80, d);
		h.cyc_io(PORT_KBCTL, 1'b0, 8'h00, d);
		chk(16'(d), 16'h0080);
		step(4);
		chk(16'(nmi_pend_r), 16'h0000);
		h.pulse(1'b1);
		step(4);
		chk(16'({nmi_r, nmi_pend_r}), 16'h0030);
		clr_nmi(NMI_KBD);
		// toggle without reading the scan code
		h.cyc_io(PORT_SCAN, 1'b1, 8'h3c, d);
		step(3);
		take(TYPE_LVL0 + 8'(LVL_KBD));
		h.cyc_io(PORT_KBCTL, 1'b1, 8'h00, d);
		h.pulse(1'b1);
		step(6);
		chk(16'(nmi_pend_r), 16'h0000);
		for (int i = 0; i < 7; i++) begin
			@(posedge clk) req <= 7'h01 << i;
			step(3);
			take(LT[i]);
			chk(16'(isr_r), 16'(8'h01 << (LT[i] - TYPE_LVL0)));
			@(posedge clk) req <= 7'h00;
			h.pulse(1'b1);
			chk(16'(isr_r), 16'h0000);
		end
		@(posedge clk) req <= 7'h20;
		step(3);
		@(posedge clk) req <= 7'h00;
		step(2);
		take(TYPE_SPUR);
		chk(16'(isr_r), 16'h0000);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			div_ovf <= TV[i][2];
			step_done <= TV[i][1];
			step_en <= TV[i][0];
			@(posedge clk);
			div_ovf <= 1'b0;
			step_done <= 1'b0;
			hits = 0;
			repeat (4) begin
				#1;
				if (trap_r === 1'b1) begin
					hits++;
					ty = trap_type_r;
				end
				@(posedge clk);
			end
			chk(16'(hits), 16'(TH[i]));
			if (TH[i] == 1) chk(16'(ty), 16'(TT[i]));
		end
		test_done();
	end
endmodule // nmi_source_and_irq_routing_test
`default_nettype wire

// file: tb/nmirt_host.sv
/*
 * host processor model: byte i/o cycles, interrupt acknowledge and
 * end-of-interrupt pulses. assumes the block samples on rising clk.
 */
`timescale 1ns/1ps
`default_nettype none
module nmirt_host (
	// clock
	input  wire logic       clk,
	// i/o cycle
	output logic [15:0]     io_addr,
	output logic            io_rd,
	output logic            io_wr,
	output logic [7:0]      io_wdata,
	input  wire logic [7:0] io_rdata_r,
	// request handshake
	output logic            inta,
	output logic            eoi
);
	initial begin
		io_addr <= 16'h0000;
		io_wdata <= 8'h00;
		io_rd <= 1'b0;
		io_wr <= 1'b0;
		inta <= 1'b0;
		eoi <= 1'b0;
	end
	// ----------------------------------------
	// bus cycles
	// ----------------------------------------
	// address and data invert once released: a stale value would hide
	// a decode that ignores the strobe
	task automatic cyc_io(input logic [15:0] a, input logic wr, input logic [7:0] dw, output logic [7:0] q);
		@(posedge clk);
		io_addr <= a;
		io_wdata <= dw;
		io_rd <= !wr;
		io_wr <= wr;
		@(posedge clk);
		io_rd <= 1'b0;
		io_wr <= 1'b0;
		io_addr <= ~a;
		io_wdata <= ~dw;
		@(posedge clk);
		#1 q = io_rdata_r;
	endtask
	// one-cycle acknowledge (0) or end-of-interrupt (1)
	task automatic pulse(input logic end_svc);
		@(posedge clk);
		if (end_svc) eoi <= 1'b1;
		else inta <= 1'b1;
		@(posedge clk);
		inta <= 1'b0;
		eoi <= 1'b0;
		@(posedge clk);
		#1;
	endtask
endmodule // nmirt_host
`default_nettype wire
